// file: inc/bwl_pkg.sv
// boot wrap/latency defaults register: constants, types, helpers
// assumes one system clock; serial pins are sampled, not clocked on
package bwl_pkg;
  localparam logic [7:0] CMD_NV_NONVOLATILE_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] CMD_REG_WRITE = 8'h01;
  localparam logic [7:0] CMD_WRITE_ANY = 8'h71;
  localparam logic [7:0] CMD_READ_ANY = 8'h65;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam int RSV_BIT = 7;
  localparam int WL_HI = 6;
  localparam int WL_LO = 5;
  localparam int WE_BIT = 4;
  localparam int RL_HI = 3;
  localparam int RL_LO = 0;
  localparam logic [7:0] NV_DEFAULT = 8'h60;
  localparam logic [3:0] DUMMY_FIXED = 4'h1;
  localparam logic [3:0] DUMMY_CODE0 = 4'h8;
  localparam logic [3:0] DUMMY_NONE = 4'h0;
  localparam logic [6:0] WRAP_MIN_BYTES = 7'h08;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0] WRR_CFG_IDX = 3'h3;
  localparam logic [2:0] WRITE_ANY_REGISTER_CMD_DATA_IDX = 3'h0;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;

  typedef enum logic [1:0] {
    CLS_FIXED_ONE = 2'b00,
    CLS_VARIABLE = 2'b01,
    CLS_QUAD_ARRAY = 2'b10,
    CLS_FIXED_ZERO = 2'b11
  } bwl_class_e;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b010,
    ST_DUMMY = 3'b011,
    ST_RDATA = 3'b100,
    ST_SKIP = 3'b101
  } bwl_state_e;

  function automatic logic [3:0] dummy_cycles(input bwl_class_e cls,
                                              input logic [3:0] code);
    logic [3:0] n;
    n = DUMMY_NONE;
    case (cls)
      CLS_FIXED_ONE: n = DUMMY_FIXED;
      CLS_VARIABLE, CLS_QUAD_ARRAY: n = (code == 4'h0) ? DUMMY_CODE0 : code;
      default: n = DUMMY_NONE;
    endcase
    return n;
  endfunction

  function automatic logic [5:0] wrap_mask(input logic [1:0] wl);
    return 6'((WRAP_MIN_BYTES << wl) - 7'h01);
  endfunction
endpackage

// file: logic/bwl_config.sv
// boot defaults register with live copy, serial access and read helper
// assumes mode-0 serial host on sampled pins, read engine on clk_sys
`timescale 1ns/1ps
`default_nettype none
module bwl_config import bwl_pkg::*; #(
  parameter logic [23:0] REG_ADDR = 24'h000003
) (
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial pins
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic si_pin,
  output var logic so_out,
  output var logic so_oe_n,
  // resets that reload the live copy
  input wire logic hw_reset_n_pin,
  input wire logic sw_reset,
  // read engine request
  input wire logic rd_req,
  input wire bwl_class_e rd_class,
  input wire logic [31:0] rd_addr,
  // read engine answer
  output var logic rd_done,
  output var logic [3:0] rd_dummy,
  output var logic rd_wrap_on,
  output var logic [31:0] rd_next_addr,
  output var logic [7:0] live_cfg
);
  logic sck_s1_r, sck_s2_r, sck_d_r;
  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic si_s1_r, si_s2_r;
  logic hwr_s1_r, hwr_s2_r;
  logic rise, fall, cs_act, cs_end;
  bwl_state_e state_r;
  logic [4:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [7:0] sh_in_r, sin_nxt, cmd_r, data_r, sh_out_r, nv_r;
  logic [23:0] addr_r;
  logic [3:0] dummy_left_r;
  logic wel_r, cap_byte, write_ok;
  logic [3:0] live_rl;
  logic live_we;
  logic [1:0] live_wl;
  logic [5:0] rd_mask;

  // pins cross into clk_sys through two stages before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
      hwr_s1_r <= 1'b1;
      hwr_s2_r <= 1'b1;
    end else begin
      sck_s1_r <= sck_pin;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      cs_s1_r <= cs_n_pin;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      si_s1_r <= si_pin;
      si_s2_r <= si_s1_r;
      hwr_s1_r <= hw_reset_n_pin;
      hwr_s2_r <= hwr_s1_r;
    end
  end

  assign rise = sck_s2_r & ~sck_d_r;
  assign fall = ~sck_s2_r & sck_d_r;
  assign cs_act = ~cs_s2_r;
  assign cs_end = cs_s2_r & ~cs_d_r;
  assign sin_nxt = {sh_in_r[6:0], si_s2_r};
  assign live_rl = live_cfg[RL_HI:RL_LO];
  assign live_we = live_cfg[WE_BIT];
  assign live_wl = live_cfg[WL_HI:WL_LO];
  assign rd_mask = wrap_mask(live_wl);
  // write-any targets one address; write-registers carries it 4th
  assign cap_byte = (state_r == ST_WDATA) && rise &&
                    (bit_cnt_r[2:0] == BYTE_LAST_BIT) &&
                    (byte_cnt_r == ((cmd_r == CMD_REG_WRITE) ?
                                    WRR_CFG_IDX : WRITE_ANY_REGISTER_CMD_DATA_IDX));
  assign write_ok = (cmd_r == CMD_REG_WRITE) ?
                    (byte_cnt_r > WRR_CFG_IDX) :
                    ((byte_cnt_r > WRITE_ANY_REGISTER_CMD_DATA_IDX) && (addr_r == REG_ADDR));

  // command sequencer, advances on sampled rising serial edges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_CMD;
      bit_cnt_r <= 5'h00;
      byte_cnt_r <= 3'h0;
      sh_in_r <= 8'h00;
      cmd_r <= CMD_NONE;
      addr_r <= 24'h000000;
      dummy_left_r <= 4'h0;
    end else if (!cs_act) begin
      state_r <= ST_CMD;
      bit_cnt_r <= 5'h00;
      byte_cnt_r <= 3'h0;
      cmd_r <= CMD_NONE;
    end else if (rise) begin
      case (state_r)
        ST_CMD: begin
          sh_in_r <= sin_nxt;
          bit_cnt_r <= (bit_cnt_r[2:0] == BYTE_LAST_BIT) ? 5'h00 :
                       5'(bit_cnt_r + 5'h01);
          if (bit_cnt_r[2:0] == BYTE_LAST_BIT) begin
            cmd_r <= sin_nxt;
            case (sin_nxt)
              CMD_REG_WRITE: state_r <= ST_WDATA;
              CMD_WRITE_ANY, CMD_READ_ANY: state_r <= ST_ADDR;
              default: state_r <= ST_SKIP;
            endcase
          end
        end
        ST_ADDR: begin
          addr_r <= {addr_r[22:0], si_s2_r};
          bit_cnt_r <= 5'(bit_cnt_r + 5'h01);
          if (bit_cnt_r == ADDR_LAST_BIT) begin
            bit_cnt_r <= 5'h00;
            state_r <= (cmd_r == CMD_READ_ANY) ? ST_DUMMY : ST_WDATA;
            dummy_left_r <= dummy_cycles(CLS_VARIABLE, live_rl);
          end
        end
        ST_WDATA: begin
          sh_in_r <= sin_nxt;
          bit_cnt_r <= (bit_cnt_r[2:0] == BYTE_LAST_BIT) ? 5'h00 :
                       5'(bit_cnt_r + 5'h01);
          if (bit_cnt_r[2:0] == BYTE_LAST_BIT && byte_cnt_r != BYTE_CNT_MAX)
            byte_cnt_r <= 3'(byte_cnt_r + 3'h1);
        end
        ST_DUMMY: begin
          dummy_left_r <= 4'(dummy_left_r - 4'h1);
          if (dummy_left_r == 4'h1)
            state_r <= ST_RDATA;
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // read-back shifter; data changes on falling edges, repeats the byte
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sh_out_r <= 8'h00;
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (!cs_act) begin
      so_oe_n <= 1'b1;
    end else if (rise && state_r == ST_DUMMY && dummy_left_r == 4'h1) begin
      sh_out_r <= (addr_r == REG_ADDR) ? nv_r : 8'h00;
    end else if (fall && state_r == ST_RDATA) begin
      so_out <= sh_out_r[7];
      so_oe_n <= 1'b0;
      sh_out_r <= {sh_out_r[6:0], sh_out_r[7]};
    end
  end

  // captured data byte for the stored register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      data_r <= 8'h00;
    else if (cap_byte)
      data_r <= sin_nxt;
  end

  // write enable latch and non-volatile store, committed at deselect
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wel_r <= 1'b0;
      nv_r <= NV_DEFAULT;
    end else if (cs_end) begin
      if (cmd_r == CMD_NV_NONVOLATILE_WRITE_ENABLE_CMD)
        wel_r <= 1'b1;
      if (cmd_r == CMD_REG_WRITE || cmd_r == CMD_WRITE_ANY) begin
        wel_r <= 1'b0;
        if (wel_r && write_ok)
          nv_r <= {1'b0, data_r[6:0]};
      end
    end
  end

  // live copy: later writes to the store wait for the next reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      live_cfg <= NV_DEFAULT;
    else if (!hwr_s2_r || sw_reset)
      live_cfg <= nv_r;
  end

  // read helper: dummy count and next burst address
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_done <= 1'b0;
      rd_dummy <= 4'h0;
      rd_wrap_on <= 1'b0;
      rd_next_addr <= 32'h00000000;
    end else begin
      rd_done <= rd_req;
      if (rd_req) begin
        rd_dummy <= dummy_cycles(rd_class, live_rl);
        rd_wrap_on <= (rd_class == CLS_QUAD_ARRAY) &&
                      !live_we;
        if ((rd_class == CLS_QUAD_ARRAY) && !live_we)
          rd_next_addr <= (rd_addr & ~{26'h0, rd_mask}) |
                          {26'h0, 6'(rd_addr[5:0] + 6'h01) &
                           rd_mask};
        else
          rd_next_addr <= 32'(rd_addr + 32'h1);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_rsv_zero;
    nv_r[RSV_BIT] == 1'b0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("rsv set");

  property p_fixed_one;
    rd_req && rd_class == CLS_FIXED_ONE |=> rd_dummy == 4'h1 && rd_done;
  endproperty
  a_fixed_one: assert property (p_fixed_one) else $error("not one");

  property p_code0;
    rd_req && rd_class == CLS_VARIABLE && live_rl == 4'h0 |=> rd_dummy == 4'h8;
  endproperty
  a_code0: assert property (p_code0) else $error("code 0 not 8");

  property p_code_n;
    rd_req && rd_class != CLS_FIXED_ONE && rd_class != CLS_FIXED_ZERO &&
      live_rl != 4'h0 |=> rd_dummy == $past(live_rl);
  endproperty
  a_code_n: assert property (p_code_n) else $error("latency code");

  property p_no_wrap_other;
    rd_req && rd_class != CLS_QUAD_ARRAY |=> !rd_wrap_on;
  endproperty
  a_no_wrap_other: assert property (p_no_wrap_other)
    else $error("stray wrap");

  property p_we_sense;
    rd_req && rd_class == CLS_QUAD_ARRAY |=> rd_wrap_on != $past(live_we);
  endproperty
  a_we_sense: assert property (p_we_sense) else $error("we sense");

  property p_group_end;
    rd_req && rd_class == CLS_QUAD_ARRAY && !live_we &&
      (rd_addr[5:0] & rd_mask) == rd_mask |=>
      (rd_next_addr[5:0] & $past(rd_mask)) == 6'h00 &&
      rd_next_addr[31:6] == $past(rd_addr[31:6]);
  endproperty
  a_group_end: assert property (p_group_end)
    else $error("wrap did not return");

  property p_linear;
    rd_req && !(rd_class == CLS_QUAD_ARRAY && !live_we) |=>
      rd_next_addr == 32'($past(rd_addr) + 32'h1);
  endproperty
  a_linear: assert property (p_linear) else $error("linear step");

  property p_reload;
    sw_reset |=> live_cfg == $past(nv_r);
  endproperty
  a_reload: assert property (p_reload) else $error("copy missed");

  property p_dummy_len;
    rise && state_r == ST_ADDR && bit_cnt_r == ADDR_LAST_BIT &&
      cmd_r == CMD_READ_ANY |=>
      dummy_left_r == $past(dummy_cycles(CLS_VARIABLE, live_rl));
  endproperty
  a_dummy_len: assert property (p_dummy_len)
    else $error("register read dummy");

  c_nv_write: cover property (cs_end && cmd_r == CMD_WRITE_ANY &&
                              wel_r && write_ok);
  c_read_back: cover property (fall && state_r == ST_RDATA);
  c_wrap_read: cover property (rd_req && rd_class == CLS_QUAD_ARRAY &&
                               !live_we);
  c_hw_reload: cover property (!hwr_s2_r);
endmodule
`default_nettype wire

// file: tb/bwl_host.sv
// serial host model: mode 0, msb first, 160 ns link clock
// assumes bench clk_sys; bench calls the command tasks by path
`timescale 1ns/1ps
`default_nettype none
module bwl_host import bwl_pkg::*; #(
  parameter logic [23:0] ADDR = 24'h000003
) (
  // system
  input wire logic clk_sys,
  // serial pins
  output var logic sck_pin,
  output var logic cs_n_pin,
  output var logic si_pin,
  input wire logic so_out,
  input wire logic so_oe_n
);
  logic oe_bad;
  initial begin
    sck_pin = 1'b0;
    cs_n_pin = 1'b1;
    si_pin = 1'b0;
    oe_bad = 1'b0;
  end
  // 80 ns half period keeps clock far below any code limit
  task automatic half();
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic clk_bit(input logic b, input logic dat, output logic r);
    si_pin = b;
    half();
    sck_pin = 1'b1;
    r = so_out;
    if (dat && so_oe_n !== 1'b0) oe_bad = 1'b1;
    half();
    sck_pin = 1'b0;
  endtask
  task automatic frame(input logic [47:0] tx, input int nb, input int nd,
                       input logic rd, output logic [7:0] q);
    logic r;
    q = 8'h00;
    cs_n_pin = 1'b0;
    half();
    for (int k = 0; k < nb; k++) clk_bit(tx[47-k], 1'b0, r);
    for (int k = 0; k < nd; k++) clk_bit(k[0], 1'b0, r);
    if (rd) for (int k = 7; k >= 0; k--) begin
      clk_bit(1'b0, 1'b1, r);
      q[k] = r;
    end
    half();
    cs_n_pin = 1'b1;
    // released line: no pull, so show the inverse of the last bit
    si_pin = ~si_pin;
    repeat (4) half();
  endtask
  // enable then write, read back by command
  task automatic nonvolatile_write_enable_cmd();
    logic [7:0] q;
    frame({CMD_NV_NONVOLATILE_WRITE_ENABLE_CMD, 40'h0}, 8, 0, 1'b0, q);
  endtask
  task automatic wr_any(input logic [7:0] d);
    logic [7:0] q;
    frame({CMD_WRITE_ANY, ADDR, d, 8'h00}, 40, 0, 1'b0, q);
  endtask
  task automatic wr_reg(input logic [7:0] d);
    logic [7:0] q;
    frame({CMD_REG_WRITE, 24'h000000, d, 8'h00}, 40, 0, 1'b0, q);
  endtask
  task automatic rd_any(input int nd, output logic [7:0] q);
    frame({CMD_READ_ANY, ADDR, 16'h0000}, 32, nd, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// file: tb/test_boot_read_latency_wrap_config.sv
// bench: read helper calls and serial register commands
// assumes bwl_config and bwl_host; live copy reloads only on resets
`timescale 1ns/1ps
`default_nettype none
module test_boot_read_latency_wrap_config;
  import bwl_pkg::*;
  logic clk_sys, reset_n, hw_reset_n_pin, sw_reset, rd_req;
  logic sck_pin, cs_n_pin, si_pin, so_out, so_oe_n, rd_done, rd_wrap_on;
  bwl_class_e rd_class;
  logic [31:0] rd_addr, rd_next_addr;
  logic [3:0] rd_dummy;
  logic [7:0] live_cfg, q, cfg, live;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  bwl_config dut (.clk_sys(clk_sys), .reset_n(reset_n), .sck_pin(sck_pin),
    .cs_n_pin(cs_n_pin), .si_pin(si_pin), .so_out(so_out),
    .so_oe_n(so_oe_n), .hw_reset_n_pin(hw_reset_n_pin),
    .sw_reset(sw_reset), .rd_req(rd_req), .rd_class(rd_class),
    .rd_addr(rd_addr), .rd_done(rd_done), .rd_dummy(rd_dummy),
    .rd_wrap_on(rd_wrap_on), .rd_next_addr(rd_next_addr),
    .live_cfg(live_cfg));
  bwl_host host (.clk_sys(clk_sys), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin),
    .si_pin(si_pin), .so_out(so_out), .so_oe_n(so_oe_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // generous ceiling: whole run needs about 9100 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input bwl_class_e c, input logic [31:0] a,
                    input logic [3:0] d, input logic w, input logic [31:0] n);
    @(negedge clk_sys);
    rd_req = 1'b1;
    rd_class = c;
    rd_addr = a;
    @(negedge clk_sys);
    rd_req = 1'b0;
    chk_val(rd_done, 1);
    chk_val(rd_dummy, d);
    chk_val(rd_wrap_on, w);
    chk_val(rd_next_addr, n);
  endtask
  function automatic logic [3:0] dmy(input logic [3:0] c);
    return (c == 4'h0) ? 4'h8 : c;
  endfunction
  initial begin
    reset_n = 1'b0;
    hw_reset_n_pin = 1'b1;
    sw_reset = 1'b0;
    rd_req = 1'b0;
    rd_class = CLS_FIXED_ONE;
    rd_addr = 32'h0;
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_val(live_cfg, 8'h60);
    rd(CLS_FIXED_ONE, 32'h10, 4'h1, 1'b0, 32'h11);
    rd(CLS_VARIABLE, 32'h3F, 4'h8, 1'b0, 32'h40);
    rd(CLS_QUAD_ARRAY, 32'h7F, 4'h8, 1'b1, 32'h40);
    rd(CLS_FIXED_ZERO, 32'h3F, 4'h0, 1'b0, 32'h40);
    live = 8'h60;
    // write without enable must be dropped
    host.wr_any(8'h15);
    host.rd_any(8, q);
    chk_val(q, 8'h60);
    for (int w = 0; w < 4; w++) begin
      cfg = {1'b1, w[1:0], 1'b0, w[1:0], 2'b11};
      host.nonvolatile_write_enable_cmd();
      if (w[0]) host.wr_reg(cfg);
      else host.wr_any(cfg);
      host.rd_any(dmy(live[3:0]), q);
      chk_val(q, {1'b0, cfg[6:0]});
      chk_val(live_cfg, live);
      if (w[0]) begin
        hw_reset_n_pin = 1'b0;
        repeat (5) @(negedge clk_sys);
        hw_reset_n_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
      end else begin
        sw_reset = 1'b1;
        @(negedge clk_sys);
        sw_reset = 1'b0;
      end
      live = {1'b0, cfg[6:0]};
      chk_val(live_cfg, live);
      rd(CLS_QUAD_ARRAY, 32'h1FF + (32'h8 << w), 4'h3 + 4'(w * 4), 1'b1,
         32'h200);
      rd(CLS_VARIABLE, 32'h200, cfg[3:0], 1'b0, 32'h201);
      rd(CLS_FIXED_ONE, 32'h10, 4'h1, 1'b0, 32'h11);
    end
    host.nonvolatile_write_enable_cmd();
    host.wr_any(8'h10);
    sw_reset = 1'b1;
    @(negedge clk_sys);
    sw_reset = 1'b0;
    rd(CLS_QUAD_ARRAY, 32'h107, 4'h8, 1'b0, 32'h108);
    chk_val(host.oe_bad, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
